// File: core/tdc_dma.sv
// Two-channel DMA engine: registers, arbitration and transfer sequencer
//
// Summary of operation
// - Source and destination pointers are 24 bits
// - At most one pointer advances per unit
// - Space: source, destination or neither advances
// - Units of 8 or 16 bits, 16-bit counter
// - Counter decrements per unit, underflow raises request
// - Twenty-five request sources per channel
// - Software bit write gives one request
// - Each hardware request edge gives one request
// - Channel zero wins simultaneous requests
// - Fixed pointer writes act at once
// - Forward pointer, counter change only at reload
// - Reload registers read and write freely
// - First transfer loads counter and forward pointer
// - One unit moves, counter down, pointer up
// - Transfers start only while channel enabled
// - One-shot underflow clears enable, sets request bit
// - Repeat underflow keeps enable, reloads, sets request
// - Repeat restarts sequence on next request
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module tdc_dma
  import tdc_pkg::*;
#(
  parameter int PERIPH_CNT = PERIPH_N
)
(
  input  wire logic                  sys_clk,   // System clock
  input  wire logic                  rst,       // Async reset, high
  input  wire tdc_reg_req_t          regReq,    // Register port request
  output logic [REG_W-1:0]           regRdata,  // Read data, next cycle
  input  wire logic                  irqPinA,   // External pin a
  input  wire logic                  irqPinB,   // External pin b
  input  wire logic [PERIPH_CNT-1:0] periphIrq, // Peripheral requests
  output tdc_mem_req_t               memReq,    // Memory bus request
  input  wire logic [DATA_W-1:0]     memRdata,  // Data after read
  output logic [1:0]                 dmaIrq     // Request bit per channel
);
  localparam int HW_N = PERIPH_CNT + 4;

  logic [1:0]        chanOn;
  logic [1:0]        rptMode;
  logic [1:0]        wideMode;
  logic [1:0]        irqFlag;
  logic [1:0]        firstXfer;
  logic [1:0]        space [2];
  logic [SEL_W-1:0]  srcSel [2];
  logic [PTR_W-1:0]  srcReload [2];
  logic [PTR_W-1:0]  dstReload [2];
  logic [PTR_W-1:0]  srcWork [2];
  logic [PTR_W-1:0]  dstWork [2];
  logic [CNT_W-1:0]  cntReload [2];
  logic [CNT_W-1:0]  cntWork [2];
  tdc_state_t        state;
  logic              curCh;
  logic              curWide;
  logic [PTR_W-1:0]  curSrc;
  logic [PTR_W-1:0]  curDst;
  logic [1:0]        pendReq;
  logic [1:0]        grantAck;
  logic [1:0]        swReq;
  logic [1:0]        wrCtrl;
  logic [1:0]        wrSel;
  logic [1:0]        wrSrc;
  logic [1:0]        wrDst;
  logic [1:0]        wrCnt;
  logic [1:0]        uflowCh;
  logic [1:0]        busyCh;
  logic              regCh;
  logic [4:0]        regOfs;
  logic              grantCh;
  logic [PTR_W-1:0]  effSrc;
  logic [PTR_W-1:0]  effDst;
  logic [PTR_W-1:0]  step;
  logic              pinAFall;
  logic              pinABoth;
  logic              pinBFall;
  logic              pinBBoth;
  logic [HW_N-1:0]   hwSrc;

  default clocking dclk @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Pin edge sources sit below the peripheral lines in the selector
  tdc_pin_edge pinA (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pinIn     (irqPinA),
    .fallPulse (pinAFall),
    .bothPulse (pinABoth)
  );

  tdc_pin_edge pinB (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pinIn     (irqPinB),
    .fallPulse (pinBFall),
    .bothPulse (pinBBoth)
  );

  assign hwSrc = {periphIrq, pinBBoth, pinBFall, pinABoth, pinAFall};

  // One selector and pending latch per channel
  for (genvar g = 0; g < 2; g++)
  begin : gReq
    tdc_req_sel #(.HW_N(HW_N)) reqSel (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .srcSel   (srcSel[g]),
      .hwIrq    (hwSrc),
      .swReq    (swReq[g]),
      .chanOn   (chanOn[g]),
      .grantAck (grantAck[g]),
      .pendReq  (pendReq[g])
    );
  end

  // Register address decode
  assign regCh  = regReq.addr[CH_BIT];
  assign regOfs = regReq.addr[CH_BIT-1:0];

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      wrCtrl[c] = regReq.we && regCh == 1'(c) && regOfs == OFS_CTRL;
      wrSel[c]  = regReq.we && regCh == 1'(c) && regOfs == OFS_SEL;
      wrSrc[c]  = regReq.we && regCh == 1'(c) && regOfs == OFS_SRC;
      wrDst[c]  = regReq.we && regCh == 1'(c) && regOfs == OFS_DST;
      wrCnt[c]  = regReq.we && regCh == 1'(c) && regOfs == OFS_CNT;
      swReq[c]  = wrCtrl[c] && regReq.wdata[CTRL_SW];
      uflowCh[c] = state == ST_WRITE && curCh == 1'(c)
                   && cntWork[c] == RST_CNT;
      busyCh[c] = state != ST_IDLE && curCh == 1'(c);
    end
  end

  // Fixed priority: channel one only when channel zero is quiet
  assign grantAck[0] = state == ST_IDLE && pendReq[0] && chanOn[0];
  assign grantAck[1] = state == ST_IDLE && pendReq[1] && chanOn[1]
                       && !grantAck[0];
  assign grantCh = !grantAck[0];

  // First unit after enabling starts from the reload values
  always_comb
  begin
    effSrc = srcWork[grantCh];
    effDst = dstWork[grantCh];
    if (firstXfer[grantCh] && space[grantCh] == SPACE_SRC_FWD)
      effSrc = srcReload[grantCh];
    if (firstXfer[grantCh] && space[grantCh] == SPACE_DST_FWD)
      effDst = dstReload[grantCh];
  end

  assign step = curWide ? STEP_WORD : STEP_BYTE;

  // Control bits; hardware underflow beats a same-cycle software write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      chanOn    <= RST_BITS;
      rptMode   <= RST_BITS;
      wideMode  <= RST_BITS;
      irqFlag   <= RST_BITS;
      firstXfer <= RST_BITS;
      space[0]  <= RST_SPACE;
      space[1]  <= RST_SPACE;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (wrCtrl[c])
        begin
          chanOn[c]   <= regReq.wdata[CTRL_EN];
          rptMode[c]  <= regReq.wdata[CTRL_RPT];
          wideMode[c] <= regReq.wdata[CTRL_WIDE];
          space[c]    <= regReq.wdata[CTRL_SP+1:CTRL_SP];
          if (regReq.wdata[CTRL_EN] && !chanOn[c])
            firstXfer[c] <= 1'b1;
          if (!regReq.wdata[CTRL_IRQ])
            irqFlag[c] <= 1'b0;
        end
        if (grantAck[c])
          firstXfer[c] <= 1'b0;
        if (uflowCh[c] && !rptMode[c])
          chanOn[c] <= 1'b0;
        if (uflowCh[c])
          irqFlag[c] <= 1'b1;
      end
    end
  end

  // Reload registers and source selectors, plain storage
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int c = 0; c < 2; c++)
      begin
        srcSel[c]    <= RST_SEL;
        srcReload[c] <= RST_PTR;
        dstReload[c] <= RST_PTR;
        cntReload[c] <= RST_CNT;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (wrSel[c])
          srcSel[c] <= regReq.wdata[SEL_W-1:0];
        if (wrSrc[c])
          srcReload[c] <= regReq.wdata[PTR_W-1:0];
        if (wrDst[c])
          dstReload[c] <= regReq.wdata[PTR_W-1:0];
        if (wrCnt[c])
          cntReload[c] <= regReq.wdata[CNT_W-1:0];
      end
    end
  end

  // Working pointers and counter; forward values only move by hardware
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int c = 0; c < 2; c++)
      begin
        srcWork[c] <= RST_PTR;
        dstWork[c] <= RST_PTR;
        cntWork[c] <= RST_CNT;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        // Writes to a fixed pointer act now, software must not race them
        if (wrSrc[c] && space[c] != SPACE_SRC_FWD)
          srcWork[c] <= regReq.wdata[PTR_W-1:0];
        if (wrDst[c] && space[c] != SPACE_DST_FWD)
          dstWork[c] <= regReq.wdata[PTR_W-1:0];
        if (grantAck[c] && firstXfer[c])
        begin
          cntWork[c] <= cntReload[c];
          if (space[c] == SPACE_SRC_FWD)
            srcWork[c] <= srcReload[c];
          if (space[c] == SPACE_DST_FWD)
            dstWork[c] <= dstReload[c];
        end
        if (state == ST_WRITE && curCh == 1'(c))
        begin
          if (uflowCh[c] && rptMode[c])
          begin
            cntWork[c] <= cntReload[c];
            if (space[c] == SPACE_SRC_FWD)
              srcWork[c] <= srcReload[c];
            if (space[c] == SPACE_DST_FWD)
              dstWork[c] <= dstReload[c];
          end
          else
          begin
            cntWork[c] <= cntWork[c] - 16'h0001;
            // Only the forward pointer steps, a both-forward code is fixed
            if (space[c] == SPACE_SRC_FWD)
              srcWork[c] <= curSrc + step;
            else if (space[c] == SPACE_DST_FWD)
              dstWork[c] <= curDst + step;
          end
        end
      end
    end
  end

  // Sequencer: read, capture, write; four cycles per unit
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state   <= ST_IDLE;
      curCh   <= 1'b0;
      curWide <= 1'b0;
      curSrc  <= RST_PTR;
      curDst  <= RST_PTR;
      memReq  <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (|grantAck)
          begin
            curCh       <= grantCh;
            curWide     <= wideMode[grantCh];
            curSrc      <= effSrc;
            curDst      <= effDst;
            memReq.rd   <= 1'b1;
            memReq.addr <= effSrc;
            memReq.wide <= wideMode[grantCh];
            state       <= ST_READ;
          end
        end
        ST_READ:
        begin
          memReq.rd <= 1'b0;
          state     <= ST_LATCH;
        end
        ST_LATCH:
        begin
          // Byte units carry zero in the upper half
          memReq.wdata <= curWide ? memRdata
                                  : {8'h00, memRdata[7:0]};
          memReq.addr  <= curDst;
          memReq.wr    <= 1'b1;
          state        <= ST_WRITE;
        end
        ST_WRITE:
        begin
          memReq.wr <= 1'b0;
          state     <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Read data for one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      regRdata <= 32'h0;
    else
    begin
      regRdata <= 32'h0;
      if (regReq.re)
      begin
        case (regOfs)
          OFS_CTRL: regRdata <= {24'h0, busyCh[regCh], irqFlag[regCh],
                                 1'b0, space[regCh], wideMode[regCh],
                                 rptMode[regCh], chanOn[regCh]};
          OFS_SEL:  regRdata <= {27'h0, srcSel[regCh]};
          OFS_SRC:  regRdata <= {8'h0, srcReload[regCh]};
          OFS_DST:  regRdata <= {8'h0, dstReload[regCh]};
          OFS_CNT:  regRdata <= {16'h0, cntReload[regCh]};
          OFS_WCNT: regRdata <= {16'h0, cntWork[regCh]};
          default:  regRdata <= 32'h0;
        endcase
      end
    end
  end

  assign dmaIrq = irqFlag;

  never_both_a: assert property (
    !$past(regReq.we) |-> !($changed(srcWork[0]) && $changed(dstWork[0])))
    else $error("both pointers moved");

  read_write_a: assert property (
    memReq.rd |=> !memReq.rd && !memReq.wr ##1 memReq.wr ##1 !memReq.wr)
    else $error("write does not follow read");

  dest_addr_a: assert property (
    memReq.wr |-> memReq.addr == curDst && !memReq.rd)
    else $error("write not at destination");

  one_shot_a: assert property (
    uflowCh[0] && !rptMode[0] |=> !chanOn[0] && irqFlag[0])
    else $error("one-shot underflow wrong");

  repeat_keep_a: assert property (
    uflowCh[1] && rptMode[1]
    |=> chanOn[1] && irqFlag[1] && cntWork[1] == $past(cntReload[1]))
    else $error("repeat underflow wrong");

  count_down_a: assert property (
    state == ST_WRITE && !curCh && cntWork[0] != RST_CNT
    |=> cntWork[0] == $past(cntWork[0]) - 16'h0001)
    else $error("counter did not decrement");

  prio_zero_a: assert property (
    state == ST_IDLE && pendReq == 2'h3 && chanOn == 2'h3
    |=> !curCh ##4 curCh)
    else $error("channel zero not served first");

  first_load_a: assert property (
    grantAck[0] && firstXfer[0] |=> cntWork[0] == $past(cntReload[0]))
    else $error("first transfer did not reload");

  fixed_write_a: assert property (
    wrDst[0] && space[0] == SPACE_FIXED && !grantAck[0]
    |=> dstWork[0] == $past(regReq.wdata[PTR_W-1:0]))
    else $error("fixed pointer write not taken");

  fwd_hold_a: assert property (
    wrSrc[0] && space[0] == SPACE_SRC_FWD && state == ST_IDLE
    && !grantAck[0] |=> $stable(srcWork[0]))
    else $error("forward pointer moved by write");

  start_on_a: assert property (
    |grantAck |-> (grantAck & chanOn) == grantAck ##1 memReq.rd)
    else $error("transfer began while disabled");

  repeat_cov: cover property (uflowCh[1] && rptMode[1] ##4 memReq.rd);
  oneshot_cov: cover property (uflowCh[0] && !rptMode[0]);
  both_cov: cover property (pendReq == 2'h3 && state == ST_IDLE);
endmodule

// File: core/tdc_pkg.sv
// Shared constants, register map and carrier types of the two-channel DMA
package tdc_pkg;
  localparam int PTR_W   = 24;
  localparam int CNT_W   = 16;
  localparam int DATA_W  = 16;
  localparam int SEL_W   = 5;
  localparam int ADDR_W  = 6;
  localparam int REG_W   = 32;
  localparam int CH_BIT  = 5;
  localparam int PERIPH_N = 20;

  // Register offsets inside one channel's window
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_SEL  = 5'h04;
  localparam logic [4:0] OFS_SRC  = 5'h08;
  localparam logic [4:0] OFS_DST  = 5'h0c;
  localparam logic [4:0] OFS_CNT  = 5'h10;
  localparam logic [4:0] OFS_WCNT = 5'h14;

  // Control register field positions
  localparam int CTRL_EN   = 0;
  localparam int CTRL_RPT  = 1;
  localparam int CTRL_WIDE = 2;
  localparam int CTRL_SP   = 3;
  localparam int CTRL_SW   = 5;
  localparam int CTRL_IRQ  = 6;

  // Transfer space encodings
  localparam logic [1:0] SPACE_FIXED   = 2'h0;
  localparam logic [1:0] SPACE_SRC_FWD = 2'h1;
  localparam logic [1:0] SPACE_DST_FWD = 2'h2;

  // Request source selector
  localparam logic [SEL_W-1:0] SEL_SOFT     = 5'h00;
  localparam logic [SEL_W-1:0] SEL_HW_BASE  = 5'h01;

  // Reset values
  localparam logic [PTR_W-1:0] RST_PTR = 24'h000000;
  localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
  localparam logic [SEL_W-1:0] RST_SEL = 5'h00;
  localparam logic [1:0]       RST_SPACE = 2'h0;
  localparam logic [1:0]       RST_BITS  = 2'h0;

  // Pointer steps per unit
  localparam logic [PTR_W-1:0] STEP_BYTE = 24'h000001;
  localparam logic [PTR_W-1:0] STEP_WORD = 24'h000002;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_LATCH = 2'h3,
    ST_WRITE = 2'h2
  } tdc_state_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
  } tdc_reg_req_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic              wide;
    logic [PTR_W-1:0]  addr;
    logic [DATA_W-1:0] wdata;
  } tdc_mem_req_t;
endpackage

// File: core/tdc_pin_edge.sv
// Pin synchroniser with falling-edge and both-edge pulse outputs
`timescale 1ns/1ps
module tdc_pin_edge
  import tdc_pkg::*;
(
  input  wire logic sys_clk,   // System clock
  input  wire logic rst,       // Async reset, high
  input  wire logic pinIn,     // Raw pin level
  output logic      fallPulse, // One cycle per falling edge
  output logic      bothPulse  // One cycle per any edge
);
  logic syncA;
  logic syncB;
  logic prevLvl;

  // Two-stage synchroniser; idle pin level assumed high
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      syncA   <= 1'b1;
      syncB   <= 1'b1;
      prevLvl <= 1'b1;
    end
    else
    begin
      syncA   <= pinIn;
      syncB   <= syncA;
      prevLvl <= syncB;
    end
  end

  // Registered edge pulses, only stage two and later are examined
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fallPulse <= 1'b0;
      bothPulse <= 1'b0;
    end
    else
    begin
      fallPulse <= prevLvl & ~syncB;
      bothPulse <= prevLvl ^ syncB;
    end
  end

  pulse_width_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    fallPulse |-> bothPulse ##1 !fallPulse)
    else $error("falling pulse malformed");
endmodule

// File: core/tdc_req_sel.sv
// Per-channel request source selector and pending request latch
`timescale 1ns/1ps
module tdc_req_sel
  import tdc_pkg::*;
#(
  parameter int HW_N = PERIPH_N + 4
)
(
  input  wire logic             sys_clk,  // System clock
  input  wire logic             rst,      // Async reset, high
  input  wire logic [SEL_W-1:0] srcSel,   // Request source choice
  input  wire logic [HW_N-1:0]  hwIrq,    // Hardware request lines
  input  wire logic             swReq,    // Software request pulse
  input  wire logic             chanOn,   // Channel enable
  input  wire logic             grantAck, // Request taken by engine
  output logic                  pendReq   // Request waiting
);
  logic [HW_N-1:0]  hwPrev;
  logic [HW_N-1:0]  hwEdge;
  logic [SEL_W-1:0] hwIdx;
  logic             trig;

  // Each rising request line counts once, levels do not repeat
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      hwPrev <= '0;
    else
      hwPrev <= hwIrq;
  end

  assign hwEdge = hwIrq & ~hwPrev;
  assign hwIdx  = srcSel - SEL_HW_BASE;

  // Source choice, out-of-range codes never fire
  always_comb
  begin
    trig = 1'b0;
    if (srcSel == SEL_SOFT)
      trig = swReq;
    else if (hwIdx < SEL_W'(HW_N))
      trig = hwEdge[hwIdx];
  end

  // New request beats the acknowledge of the old one
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pendReq <= 1'b0;
    else if (!chanOn)
      pendReq <= 1'b0;
    else if (trig)
      pendReq <= 1'b1;
    else if (grantAck)
      pendReq <= 1'b0;
  end

  drop_off_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !chanOn |=> !pendReq)
    else $error("request kept while disabled");

  held_wait_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    pendReq && !grantAck && chanOn |=> pendReq)
    else $error("pending request lost");

  soft_trig_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    chanOn && srcSel == SEL_SOFT && swReq |=> pendReq)
    else $error("software request missed");
endmodule

// File: tb/tdc_mem_model.sv
// Behavioural memory answering the engine's read cycles; write cycles are ignored
`timescale 1ns/1ps
module tdc_mem_model
  import tdc_pkg::*;
(
  input  wire logic         sys_clk,  // System clock
  input  wire logic         rst,      // Async reset, high
  input  wire tdc_mem_req_t memReq,   // Request from the engine
  output logic [DATA_W-1:0] memRdata  // Data, only in cycle after rd
);
  // Read data stand one cycle only; otherwise they toggle so that
  // a late sample by the engine cannot match by luck
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      memRdata <= 16'h0000;
    else if (memReq.rd)
      memRdata <= memReq.addr[15:0] ^ 16'h3c5a;
    else
      memRdata <= ~memRdata;
  end
endmodule

// File: tb/tdc_dma_test.sv
// Self-checking bench for the two-channel DMA engine
`timescale 1ns/1ps
module tdc_dma_test
  import tdc_pkg::*;
;
  logic                sys_clk;
  logic                rst;
  tdc_reg_req_t        regReq;
  logic [REG_W-1:0]    regRdata;
  logic                irqPinA;
  logic                irqPinB;
  logic [PERIPH_N-1:0] periphIrq;
  tdc_mem_req_t        memReq;
  logic [DATA_W-1:0]   memRdata;
  logic [1:0]          dmaIrq;
  logic [40:0]         expQ[$];
  logic [40:0]         got;
  logic [PTR_W-1:0]    s, d, s2, d2;
  int                  bad_count;
  int                  total_checks;
  int                  p, i;

  tdc_dma dut
  (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .regReq    (regReq),
    .regRdata  (regRdata),
    .irqPinA   (irqPinA),
    .irqPinB   (irqPinB),
    .periphIrq (periphIrq),
    .memReq    (memReq),
    .memRdata  (memRdata),
    .dmaIrq    (dmaIrq)
  );

  tdc_mem_model mem
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .memReq   (memReq),
    .memRdata (memRdata)
  );

  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One-cycle register strobes, launched just after an edge
  task automatic wr(input logic c, input logic [4:0] o, input logic [31:0] v);
    @(posedge sys_clk);
    regReq <= '{1'b1, 1'b0, {c, o}, v};
    @(posedge sys_clk);
    regReq <= '0;
  endtask

  task automatic rd(input logic c, input logic [4:0] o, input logic [31:0] e);
    @(posedge sys_clk);
    regReq <= '{1'b0, 1'b1, {c, o}, 32'h0};
    @(posedge sys_clk);
    regReq <= '0;
    #1;
    chk(regRdata === e, "register read");
  endtask

  function automatic logic [15:0] mf(input logic [PTR_W-1:0] a);
    return a[15:0] ^ 16'h3c5a;
  endfunction

  function automatic logic [31:0] cw(input logic [1:0] sp, input logic w, r);
    cw = 32'h1;
    cw[CTRL_RPT] = r;
    cw[CTRL_WIDE] = w;
    cw[CTRL_SP +: 2] = sp;
  endfunction

  // Byte units carry zero in the upper half
  function automatic void expw(input logic w, input logic [PTR_W-1:0] sa, da);
    expQ.push_back({w, da, mf(sa) & (w ? 16'hffff : 16'h00ff)});
  endfunction

  // Note the expected write, then fire one software request
  task automatic unit(input logic c, input logic [31:0] cv, input logic w,
                      input logic [PTR_W-1:0] sa, da);
    expw(w, sa, da);
    wr(c, OFS_CTRL, cv | 32'h20);
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic pin(input logic a, input logic v);
    @(posedge sys_clk);
    if (a)
      irqPinA <= v;
    else
      irqPinB <= v;
    repeat (12) @(posedge sys_clk);
  endtask

  // Every memory write is matched against the oldest note
  always @(posedge sys_clk)
  begin
    if (memReq.wr === 1'b1)
    begin
      if (expQ.size() == 0)
        chk(1'b0, "unexpected memory write");
      else
      begin
        got = expQ.pop_front();
        chk({memReq.wide, memReq.addr, memReq.wdata} === got, "mem write");
      end
    end
  end

  // Watchdog far beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    regReq = '0;
    irqPinA = 1'b1;
    irqPinB = 1'b1;
    periphIrq = '0;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(49));
    s = 24'($urandom());
    d = 24'($urandom());
    s2 = 24'($urandom());
    d2 = 24'($urandom());
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(1'b0, OFS_CTRL, 32'h0);
    wr(1'b0, OFS_SRC, 32'hff000000 | {8'h00, s});
    rd(1'b0, OFS_SRC, {8'h00, s});
    rd(1'b0, 5'h18, 32'h0);
    $display("test registers done");
    // One-shot, bytes, source advances, three units
    wr(1'b0, OFS_DST, {8'h00, d});
    wr(1'b0, OFS_CNT, 32'h2);
    wr(1'b0, OFS_CTRL, cw(SPACE_SRC_FWD, 1'b0, 1'b0));
    for (i = 0; i < 3; i++)
    begin
      unit(1'b0, cw(SPACE_SRC_FWD, 1'b0, 1'b0), 1'b0, s + 24'(i), d);
      // Forward pointer rewrite must not disturb the running sequence
      if (i == 0)
        wr(1'b0, OFS_SRC, {8'h00, s2});
    end
    rd(1'b0, OFS_SRC, {8'h00, s2});
    rd(1'b0, OFS_CTRL, 32'h48);
    chk(dmaIrq === 2'b01, "channel zero request bit");
    wr(1'b0, OFS_CTRL, 32'h20);
    wr(1'b0, OFS_CTRL, cw(SPACE_SRC_FWD, 1'b0, 1'b0));
    repeat (10) @(posedge sys_clk);
    chk(expQ.size() == 0, "one-shot writes missing");
    $display("test one-shot done");
    // Repeat, words, destination advances, pointers rewritten midway
    wr(1'b1, OFS_SRC, {8'h00, s});
    wr(1'b1, OFS_DST, {8'h00, d});
    wr(1'b1, OFS_CNT, 32'h1);
    wr(1'b1, OFS_CTRL, cw(SPACE_DST_FWD, 1'b1, 1'b1));
    unit(1'b1, cw(SPACE_DST_FWD, 1'b1, 1'b1), 1'b1, s, d);
    wr(1'b1, OFS_SRC, {8'h00, s2});
    wr(1'b1, OFS_DST, {8'h00, d2});
    unit(1'b1, cw(SPACE_DST_FWD, 1'b1, 1'b1), 1'b1, s2, d + 24'h2);
    rd(1'b1, OFS_CTRL, 32'h57);
    chk(dmaIrq === 2'b10, "channel one request bit");
    unit(1'b1, cw(SPACE_DST_FWD, 1'b1, 1'b1), 1'b1, s2, d2);
    rd(1'b1, OFS_WCNT, 32'h0);
    rd(1'b1, OFS_DST, {8'h00, d2});
    $display("test repeat done");
    // Same peripheral line on both channels: channel zero first
    p = $urandom_range(19);
    for (i = 0; i < 2; i++)
    begin
      wr(i[0], OFS_CTRL, 32'h0);
      wr(i[0], OFS_SEL, 32'(5'd5 + 5'(p)));
      wr(i[0], OFS_SRC, {8'h00, s + 24'(i)});
      wr(i[0], OFS_DST, {8'h00, d2 + 24'(i)});
      wr(i[0], OFS_CNT, 32'h5);
      wr(i[0], OFS_CTRL, cw(SPACE_FIXED, 1'b0, 1'b0));
      expw(1'b0, s + 24'(i), d2 + 24'(i));
    end
    @(posedge sys_clk);
    periphIrq[p] <= 1'b1;
    repeat (16) @(posedge sys_clk);
    periphIrq[p] <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(expQ.size() == 0, "peripheral writes missing");
    $display("test priority done");
    // Pin sources: falling only on one channel, both edges on the other
    wr(1'b0, OFS_SEL, 32'h1);
    wr(1'b1, OFS_SEL, 32'h4);
    expw(1'b0, s, d2);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    expw(1'b0, s + 24'h1, d2 + 24'h1);
    expw(1'b0, s + 24'h1, d2 + 24'h1);
    pin(1'b0, 1'b0);
    pin(1'b0, 1'b1);
    chk(expQ.size() == 0, "pin writes missing");
    $display("test pins done");
    complete_run();
  end
endmodule
